// File: logic/dacsg_pkg.sv
// Notes on behaviour
// - Keep-running bit keeps converter alive in standby while peripheral clock available
// - Otherwise standby halts, powers down converter, buffer
// - Standby exit re-enables; start-up delay before conversion
// - Power-down always disables converter and buffer
// - Control at 0x00, bits 7,6,0, reset zero
// - Pin buffer enable drives output to pin
// - Converter enable bit powers converter on
// - Data register at 0x01, eight bits, reset zero
// - Data write while enabled starts conversion
// - Disabled data write waits for enable write
// - Writing enable zero disables converter
// - Internal output available once converter running, not during start-up
package dacsg_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [1:0] CTRL_IDX      = 2'h0;
    localparam logic [1:0] VALUE_IDX     = 2'h1;
    localparam logic [1:0] SLEEP_IDX     = 2'h2;
    localparam logic [1:0] STATUS_IDX    = 2'h3;
    localparam logic [7:0] CTRL_RESET    = 8'h00;
    localparam logic [7:0] VALUE_RESET   = 8'h00;
    localparam int         KEEP_BIT      = 7;
    localparam int         PINBUF_BIT    = 6;
    localparam int         ENABLE_BIT    = 0;
    localparam logic [7:0] CTRL_MASK     = 8'hc1;

    // ------------------------------------------------------------
    // Sleep modes written by the power manager
    // ------------------------------------------------------------
    localparam logic [1:0] SLEEP_ACTIVE  = 2'h0;
    localparam logic [1:0] SLEEP_STANDBY = 2'h1;
    localparam logic [1:0] SLEEP_PDOWN   = 2'h2;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ       = 100;
    localparam int STARTUP_NS    = 1000;
    localparam int STARTUP_CYC   = (STARTUP_NS * CLK_MHZ + 999) / 1000;

    typedef enum logic [1:0] {
        DACSG_OFF     = 2'b00,
        DACSG_STARTUP = 2'b01,
        DACSG_RUN     = 2'b10,
        DACSG_HALTED  = 2'b11
    } dacsg_state_t;

endpackage

// File: logic/dacsg_startup_timer.sv
`timescale 1ns/1ps
// Counts the analog start-up interval after a power-up request.
module dacsg_startup_timer #(
    parameter int CYCLES = dacsg_pkg::STARTUP_CYC
) (
    input  wire logic clk,
    input  wire logic sys_rst,
    input  wire logic ce,
    input  wire logic start,
    input  wire logic abort,
    output logic      done
);
    localparam int W = $clog2(CYCLES + 1);

    // Elaboration check: a zero-length interval cannot be counted
    if (CYCLES < 1) begin : g_bad_cycles
        $error("CYCLES must be at least one");
    end

    logic [W-1:0] cnt_r;
    logic [W-1:0] cnt_nxt;
    logic         done_r;
    logic         done_nxt;

    // ------------------------------------------------------------
    // Down counter
    // ------------------------------------------------------------
    always_comb begin
        cnt_nxt  = cnt_r;
        done_nxt = 1'b0;
        if (abort) begin
            cnt_nxt = '0;
        end else if (start) begin
            cnt_nxt = W'(CYCLES);
        end else if (cnt_r != '0) begin
            cnt_nxt  = cnt_r - 1'b1;
            done_nxt = (cnt_r == W'(1));
        end
    end

    // Registering only
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cnt_r  <= '0;
            done_r <= 1'b0;
        end else if (ce) begin
            cnt_r  <= cnt_nxt;
            done_r <= done_nxt;
        end
    end

    assign done = done_r;
endmodule // dacsg_startup_timer

// File: logic/dacsg_top.sv
// Chosen here: the Wishbone register port.
`timescale 1ns/1ps
// Control logic of an 8-bit voltage-output converter with sleep gating.
module dacsg_top #(
    parameter int STARTUP_CYCLES = dacsg_pkg::STARTUP_CYC
) (
    input  wire logic       clk,
    input  wire logic       sys_rst,
    input  wire logic       ce,
    input  wire logic       clkPerAvail,
    input  wire logic       wb_cyc_i,
    input  wire logic       wb_stb_i,
    input  wire logic       wb_we_i,
    input  wire logic [3:0] wb_adr_i,
    input  wire logic [3:0] wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic [31:0]     wb_dat_o,
    output logic            wb_ack_o,
    output logic            wb_err_o,
    output logic            convEnable,
    output logic            bufEnable,
    output logic            internalValid,
    output logic [7:0]      convLevel,
    output logic            convStart
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [7:0]          ctrl_r,   ctrl_nxt;
    logic [7:0]          value_r,  value_nxt;
    logic [1:0]          sleep_r,  sleep_nxt;
    logic                pend_r,   pend_nxt;
    dacsg_pkg::dacsg_state_t st_r, st_nxt;
    logic [31:0]         rdat_r,   rdat_nxt;
    logic                ack_r,    ack_nxt;
    logic                err_r,    err_nxt;
    logic                cen_r,    cen_nxt;
    logic                buf_r,    buf_nxt;
    logic                ival_r,   ival_nxt;
    logic [7:0]          lvl_r,    lvl_nxt;
    logic                start_r,  start_nxt;
    logic [2:0]          avSync_r;
    logic                avail_r,  avail_nxt;
    logic                tmrStart;
    logic                tmrAbort;
    logic                tmrDone;

    // Clock-available flag crosses from the clock controller: three stages;
    // a change is accepted only once the last two stages agree
    always_comb begin
        avail_nxt = avail_r;
        if (avSync_r[2] == avSync_r[1]) begin
            avail_nxt = avSync_r[2];
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            avSync_r <= 3'h0;
            avail_r  <= 1'b0;
        end else if (ce) begin
            avSync_r <= {avSync_r[1:0], clkPerAvail};
            avail_r  <= avail_nxt;
        end
    end

    // Word-aligned hit on one register index; all inputs are arguments so
    // the continuous assignments below follow every bus signal
    function automatic logic reg_hit(input logic [3:0] adr, input logic [1:0] idx);
        reg_hit = (adr[3:2] == idx) && (adr[1:0] == 2'b00);
    endfunction

    logic reqValid;
    logic wrReq;
    logic wrCtrl;
    logic wrValue;
    logic wrSleep;
    logic runAllowed;
    logic [7:0] wd;
    assign reqValid = wb_cyc_i && wb_stb_i && !ack_r && !err_r;
    assign wd       = wb_dat_i[7:0];
    assign wrReq    = reqValid && wb_we_i && wb_sel_i[0];
    assign wrCtrl   = wrReq && reg_hit(wb_adr_i, dacsg_pkg::CTRL_IDX);
    assign wrValue  = wrReq && reg_hit(wb_adr_i, dacsg_pkg::VALUE_IDX);
    assign wrSleep  = wrReq && reg_hit(wb_adr_i, dacsg_pkg::SLEEP_IDX);

    // ------------------------------------------------------------
    // Bus slave: one-cycle ack, err on misaligned access only
    // ------------------------------------------------------------
    always_comb begin
        ctrl_nxt  = ctrl_r;
        value_nxt = value_r;
        sleep_nxt = sleep_r;
        rdat_nxt  = rdat_r;
        ack_nxt   = 1'b0;
        err_nxt   = 1'b0;
        if (reqValid) begin
            if (wb_adr_i[1:0] != 2'b00) begin
                err_nxt = 1'b1;
            end else begin
                ack_nxt = 1'b1;
                if (wrCtrl) ctrl_nxt = wd & dacsg_pkg::CTRL_MASK;
                if (wrValue) value_nxt = wd;
                if (wrSleep) sleep_nxt = wd[1:0];
                case (wb_adr_i[3:2])
                    dacsg_pkg::CTRL_IDX:   rdat_nxt = {24'h000000, ctrl_r};
                    dacsg_pkg::VALUE_IDX:  rdat_nxt = {24'h000000, value_r};
                    dacsg_pkg::SLEEP_IDX:  rdat_nxt = {30'h00000000, sleep_r};
                    dacsg_pkg::STATUS_IDX: rdat_nxt = {28'h0000000, pend_r, st_r, tmrDone};
                    default:               rdat_nxt = 32'h00000000;
                endcase
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ctrl_r  <= dacsg_pkg::CTRL_RESET;
            value_r <= dacsg_pkg::VALUE_RESET;
            sleep_r <= dacsg_pkg::SLEEP_ACTIVE;
            rdat_r  <= 32'h00000000;
            ack_r   <= 1'b0;
            err_r   <= 1'b0;
        end else if (ce) begin
            ctrl_r  <= ctrl_nxt;
            value_r <= value_nxt;
            sleep_r <= sleep_nxt;
            rdat_r  <= rdat_nxt;
            ack_r   <= ack_nxt;
            err_r   <= err_nxt;
        end
    end

    // ------------------------------------------------------------
    // Power and conversion sequencing
    // ------------------------------------------------------------
    // keep running only with clock present; power-down wins
    assign runAllowed = ctrl_r[dacsg_pkg::ENABLE_BIT]
        && (sleep_r != dacsg_pkg::SLEEP_PDOWN)
        && ((sleep_r != dacsg_pkg::SLEEP_STANDBY)
            || (ctrl_r[dacsg_pkg::KEEP_BIT] && avail_r));

    always_comb begin
        st_nxt    = st_r;
        pend_nxt  = pend_r;
        lvl_nxt   = lvl_r;
        start_nxt = 1'b0;
        tmrStart  = 1'b0;
        tmrAbort  = 1'b0;
        // data written while off waits for enable
        if (wrValue) pend_nxt = 1'b1;
        case (st_r)
            dacsg_pkg::DACSG_OFF: begin
                if (runAllowed) begin
                    st_nxt   = dacsg_pkg::DACSG_RUN;
                    lvl_nxt  = value_nxt;
                    start_nxt = 1'b1;
                    pend_nxt = 1'b0;
                end
            end
            dacsg_pkg::DACSG_RUN: begin
                if (!ctrl_r[dacsg_pkg::ENABLE_BIT]) begin
                    st_nxt = dacsg_pkg::DACSG_OFF;
                end else if (!runAllowed) begin
                    st_nxt = dacsg_pkg::DACSG_HALTED;
                end else if (wrValue) begin
                    lvl_nxt   = wd;
                    start_nxt = 1'b1;
                    pend_nxt  = 1'b0;
                end
            end
            dacsg_pkg::DACSG_HALTED: begin
                // wake: power up then wait start-up
                if (!ctrl_r[dacsg_pkg::ENABLE_BIT]) begin
                    st_nxt = dacsg_pkg::DACSG_OFF;
                end else if (runAllowed) begin
                    st_nxt   = dacsg_pkg::DACSG_STARTUP;
                    tmrStart = 1'b1;
                end
            end
            dacsg_pkg::DACSG_STARTUP: begin
                if (!runAllowed) begin
                    tmrAbort = 1'b1;
                    st_nxt   = ctrl_r[dacsg_pkg::ENABLE_BIT] ? dacsg_pkg::DACSG_HALTED : dacsg_pkg::DACSG_OFF;
                end else if (tmrDone) begin
                    st_nxt    = dacsg_pkg::DACSG_RUN;
                    lvl_nxt   = value_nxt;
                    start_nxt = 1'b1;
                    pend_nxt  = 1'b0;
                end
            end
            default: st_nxt = dacsg_pkg::DACSG_OFF;
        endcase
    end

    // Output enables: converter on in startup/run; buffer only when pin enable set
    always_comb begin
        cen_nxt  = (st_nxt == dacsg_pkg::DACSG_RUN) || (st_nxt == dacsg_pkg::DACSG_STARTUP);
        buf_nxt  = cen_nxt && ctrl_nxt[dacsg_pkg::PINBUF_BIT];
        ival_nxt = (st_nxt == dacsg_pkg::DACSG_RUN);
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st_r    <= dacsg_pkg::DACSG_OFF;
            pend_r  <= 1'b0;
            lvl_r   <= dacsg_pkg::VALUE_RESET;
            start_r <= 1'b0;
            cen_r   <= 1'b0;
            buf_r   <= 1'b0;
            ival_r  <= 1'b0;
        end else if (ce) begin
            st_r    <= st_nxt;
            pend_r  <= pend_nxt;
            lvl_r   <= lvl_nxt;
            start_r <= start_nxt;
            cen_r   <= cen_nxt;
            buf_r   <= buf_nxt;
            ival_r  <= ival_nxt;
        end
    end

    dacsg_startup_timer #(
        .CYCLES (STARTUP_CYCLES)
    ) u_timer (
        .clk     (clk),
        .sys_rst (sys_rst),
        .ce      (ce),
        .start   (tmrStart),
        .abort   (tmrAbort),
        .done    (tmrDone)
    );

    assign wb_dat_o      = rdat_r;
    assign wb_ack_o      = ack_r;
    assign wb_err_o      = err_r;
    assign convEnable    = cen_r;
    assign bufEnable     = buf_r;
    assign internalValid = ival_r;
    assign convLevel     = lvl_r;
    assign convStart     = start_r;
endmodule // dacsg_top

// File: dv/dacsg_checker.sv
`timescale 1ns/1ps
// ------------------------------
// Port checker for sleep gating
// ------------------------------
module dacsg_checker #(
    parameter int STARTUP_CYCLES = 2
) (
    input wire logic        clk,
    input wire logic        sys_rst,
    input wire logic        clkPerAvail,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [3:0]  wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic        wb_ack_o,
    input wire logic        wb_err_o,
    input wire logic        convEnable,
    input wire logic        bufEnable,
    input wire logic        internalValid,
    input wire logic [7:0]  convLevel,
    input wire logic        convStart
);
    logic       take;
    logic       haltNow;
    logic [7:0] ctrlR;
    logic [7:0] valR;
    logic [1:0] sleepR;
    logic [3:0] availR;
    // Taken request; shadows follow software so no design internals are needed
    assign take = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
    assign haltNow = sleepR == dacsg_pkg::SLEEP_STANDBY && !ctrlR[7];
    // Shadow registers updated at the edge a write is taken
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ctrlR  <= 8'h00;
            valR   <= 8'h00;
            sleepR <= 2'h0;
        end else if (take && wb_we_i && wb_sel_i[0]) begin
            if (wb_adr_i == 4'h0) ctrlR <= wb_dat_i[7:0] & dacsg_pkg::CTRL_MASK;
            if (wb_adr_i == 4'h4) valR <= wb_dat_i[7:0];
            if (wb_adr_i == 4'h8) sleepR <= wb_dat_i[1:0];
        end
    end
    // Clock-available history; the design synchroniser lags this
    always_ff @(posedge clk) availR <= {availR[2:0], clkPerAvail};
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);
    sequence sDataWr;
        take && wb_we_i && wb_sel_i[0] && wb_adr_i == 4'h4;
    endsequence
    sequence sCtrlWr;
        take && wb_we_i && wb_sel_i[0] && wb_adr_i == 4'h0;
    endsequence
    // Bus answers
    a_ack_next:
    assert property (take |=> (wb_ack_o ^ wb_err_o)) else $error("bus answer missing");
    // Conversion starts
    a_data_start:
    assert property (sDataWr ##0 internalValid |=> convStart && convLevel == $past(wb_dat_i[7:0]))
        else $error("data write did not start conversion");
    a_idle_write:
    assert property (sDataWr ##0 !ctrlR[0] |=> !convStart && $stable(convLevel))
        else $error("disabled data write started conversion");
    a_enable_start:
    assert property (sCtrlWr ##0 (wb_dat_i[0] && !ctrlR[0] && sleepR == dacsg_pkg::SLEEP_ACTIVE)
        |=> ##1 (convStart && convEnable && convLevel == valR)) else $error("enable did not start");
    a_disable_off:
    assert property (sCtrlWr ##0 !wb_dat_i[0] |=> ##1 !convEnable) else $error("disable ignored");
    // Sleep gating, judged once the mode has settled
    a_pdown_off:
    assert property (sleepR == dacsg_pkg::SLEEP_PDOWN [*3] |-> !convEnable && !bufEnable)
        else $error("power-down left converter on");
    a_standby_halt:
    assert property (haltNow && $past(haltNow) && $past(haltNow, 2) |-> !convEnable && !bufEnable)
        else $error("standby did not halt");
    a_keep_run:
    assert property (sleepR == dacsg_pkg::SLEEP_STANDBY && ctrlR[7] && (&availR) && internalValid
        && !wb_stb_i |=> internalValid) else $error("standby stopped a kept converter");
    a_buf_follows:
    assert property (bufEnable |-> ctrlR[6] || $past(ctrlR[6])) else $error("buffer on without enable");
    a_internal_on:
    assert property (internalValid |-> convEnable) else $error("internal output without converter");
endmodule // dacsg_checker
bind dacsg_top dacsg_checker #(.STARTUP_CYCLES(STARTUP_CYCLES)) u_chk (
    .clk(clk), .sys_rst(sys_rst), .clkPerAvail(clkPerAvail), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .convEnable(convEnable),
    .bufEnable(bufEnable), .internalValid(internalValid), .convLevel(convLevel), .convStart(convStart)
);

// File: dv/dacsg_tb_top.sv
`timescale 1ns/1ps
// ------------------------------
// Converter control testbench
// ------------------------------
module dacsg_tb_top;
    localparam int STARTUP = 4;
    logic        clk, sys_rst, ce, clkPerAvail, cyc, stb, we, ack, err;
    logic        convEnable, bufEnable, internalValid, convStart;
    logic [3:0]  adr, sel;
    logic [31:0] datW, datR;
    logic [7:0]  convLevel, lvlSeen;
    int          errors, samplesChecked, startCnt = 0;
    dacsg_top #(.STARTUP_CYCLES(STARTUP)) u_dut (
        .clk(clk), .sys_rst(sys_rst), .ce(ce), .clkPerAvail(clkPerAvail),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(datW), .wb_dat_o(datR), .wb_ack_o(ack), .wb_err_o(err),
        .convEnable(convEnable), .bufEnable(bufEnable), .internalValid(internalValid),
        .convLevel(convLevel), .convStart(convStart)
    );
    // Start pulses last one cycle, so count them here rather than in the tasks
    always @(posedge clk) if (convStart === 1'b1) begin
        startCnt <= startCnt + 1;
        lvlSeen <= convLevel;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samplesChecked++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic end_sim();
        $display("errors %0d comparisons %0d", errors, samplesChecked);
        if (errors == 0 && samplesChecked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // One classic cycle; held until ack or err is seen high at a rising edge
    task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d,
                       output logic [31:0] r, output logic e);
        int n;
        n = 0;
        @(posedge clk);
        {cyc, stb, we, adr, datW} <= {1'b1, 1'b1, w, a, 24'h0, d};
        // Answer is judged at the rising edge itself, before that edge updates it
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && err !== 1'b1 && n < 20);
        r = datR;
        e = err;
        {cyc, stb, we} <= 3'b000;
        if (n >= 20) begin
            errors++;
            end_sim();
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        logic [31:0] r;
        logic        e;
        bus(1'b1, a, d, r, e);
    endtask
    task automatic rdchk(input logic [3:0] a, input logic [31:0] x);
        logic [31:0] r;
        logic        e;
        bus(1'b0, a, 8'h00, r, e);
        check(r, x);
    endtask
    // Bounded wait for the next start pulse; returns cycles waited
    task automatic await_start(output int n);
        int s0 = startCnt;
        n = 0;
        while (startCnt == s0 && n < 200) begin
            @(negedge clk);
            n++;
        end
        if (n >= 200) begin
            errors++;
            end_sim();
        end
    endtask
    // Reset values, then a data write made while the converter is off
    task automatic t_disabled();
        int s0 = startCnt;
        rdchk(4'h0, 32'h0);
        rdchk(4'h4, 32'h0);
        wr(4'h4, 8'h3c);
        repeat (3) @(posedge clk);
        check(32'(startCnt - s0), 32'h0);
        check(32'(convLevel), 32'h0);
        wr(4'h0, 8'h01);
        repeat (2) @(posedge clk);
        check(32'(startCnt - s0), 32'h1);
        check(32'(lvlSeen), 32'h3c);
        check(32'({convEnable, bufEnable, internalValid}), 32'h5);
    endtask
    // Enabled writes start at once; register masks; misaligned access refused
    task automatic t_enabled();
        int s0 = startCnt;
        logic [31:0] r;
        logic        e;
        wr(4'h4, 8'h5a);
        @(posedge clk);
        check(32'(startCnt - s0), 32'h1);
        check(32'(lvlSeen), 32'h5a);
        rdchk(4'h4, 32'h5a);
        wr(4'h0, 8'hff);
        rdchk(4'h0, 32'hc1);
        check(32'(bufEnable), 32'h1);
        bus(1'b1, 4'h2, 8'h00, r, e);
        check(32'(e), 32'h1);
    endtask
    // Standby halt and restart after the start-up interval
    task automatic t_standby();
        int n;
        wr(4'h0, 8'h41);
        wr(4'h8, 8'h01);
        repeat (4) @(posedge clk);
        check(32'({convEnable, bufEnable}), 32'h0);
        wr(4'h8, 8'h00);
        await_start(n);
        check(32'(n >= STARTUP - 1 && n <= STARTUP + 4), 32'h1);
        check(32'({convEnable, bufEnable, lvlSeen}), 32'h35a);
    endtask
    // Keep-running standby, then loss of the peripheral clock
    task automatic t_keep();
        int n;
        int s0;
        wr(4'h0, 8'hc1);
        wr(4'h8, 8'h01);
        repeat (4) @(posedge clk);
        check(32'({convEnable, internalValid}), 32'h3);
        s0 = startCnt;
        wr(4'h4, 8'h77);
        @(posedge clk);
        check(32'(startCnt - s0), 32'h1);
        clkPerAvail <= 1'b0;
        repeat (8) @(posedge clk);
        check(32'(convEnable), 32'h0);
        wr(4'h8, 8'h00);
        clkPerAvail <= 1'b1;
        await_start(n);
        check(32'(lvlSeen), 32'h77);
    endtask
    // Power-down overrides keep-running; clearing enable turns off
    task automatic t_pdown();
        int n;
        wr(4'h8, 8'h02);
        repeat (4) @(posedge clk);
        check(32'({convEnable, bufEnable, internalValid}), 32'h0);
        wr(4'h8, 8'h00);
        await_start(n);
        wr(4'h0, 8'h00);
        repeat (2) @(posedge clk);
        check(32'(convEnable), 32'h0);
        rdchk(4'h0, 32'h0);
    endtask
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        {sys_rst, ce, clkPerAvail, cyc, stb, we, adr, sel, datW} = {5'h1c, 1'b0, 4'h0, 4'hf, 32'h0};
        errors = 0;
        samplesChecked = 0;
        repeat (8) @(posedge clk);
        sys_rst <= 1'b0;
        t_disabled();
        t_enabled();
        t_standby();
        t_keep();
        t_pdown();
        end_sim();
    end
endmodule // dacsg_tb_top
